// ==== include/pcmt_pkg.sv ====
package pcmt_pkg;

  // ----------------------------------------------------------------
  // message type codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MSG_LTR = 3'h0;
  localparam logic [2:0] MSG_OBFF = 3'h1;
  localparam logic [2:0] MSG_SSPL = 3'h2;
  localparam logic [2:0] MSG_PME = 3'h3;

  // ----------------------------------------------------------------
  // latency report field positions
  // ----------------------------------------------------------------
  localparam int LTR_SNP_REQ_BIT = 31;
  localparam int LTR_SNP_PASID_HI = 30;
  localparam int LTR_SNP_PASID_LO = 29;
  localparam int LTR_SNP_SCALE_HI = 28;
  localparam int LTR_SNP_SCALE_LO = 26;
  localparam int LTR_SNP_VAL_HI = 25;
  localparam int LTR_SNP_VAL_LO = 16;
  localparam int LTR_NSP_REQ_BIT = 15;
  localparam int LTR_NSP_PASID_HI = 14;
  localparam int LTR_NSP_PASID_LO = 13;
  localparam int LTR_NSP_SCALE_HI = 12;
  localparam int LTR_NSP_SCALE_LO = 10;
  localparam int LTR_NSP_VAL_HI = 9;
  localparam int LTR_NSP_VAL_LO = 0;

  // ----------------------------------------------------------------
  // sideband positions and other fields
  // ----------------------------------------------------------------
  localparam int SB_WIDTH = 183;
  localparam int SB_SNP_PASID_HI = 182;
  localparam int SB_SNP_PASID_LO = 181;
  localparam int SB_NSP_PASID_HI = 180;
  localparam int SB_NSP_PASID_LO = 179;
  localparam int SSPL_HI = 9;
  localparam int PME_FN_HI = 7;
  localparam logic [7:0] PME_FN_MAX = 8'h03;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DONE_PULSE_CYCLES = 1;
  localparam int DEF_PROC_CYCLES = 4;

endpackage

// ==== include/pcmt_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// request / completion carrier between user logic and the core
interface pcmt_if;
  logic msg_tx_request_alias;
  logic [2:0] msg_tx_type;
  logic [31:0] msg_tx_data;
  logic msg_tx_done;

  modport core (
    input msg_tx_request_alias, msg_tx_type, msg_tx_data,
    output msg_tx_done
  );
  modport user (
    output msg_tx_request_alias, msg_tx_type, msg_tx_data,
    input msg_tx_done
  );
endinterface
`default_nettype wire

// ==== src/pcmt_user.sv ====
`timescale 1ns/10ps
`default_nettype none
// user side: takes one command, holds it on the link until done
module pcmt_user (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_type_i,
  input wire logic [31:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  // link
  pcmt_if.user link
);

  logic req_reg, req_next;
  logic [2:0] type_reg, type_next;
  logic [31:0] data_reg, data_next;
  logic done_reg, done_next;
  logic ready_reg, ready_next;
  logic cmd_legal;

  // reserved codes and reserved pme functions never leave this end
  assign cmd_legal = (cmd_type_i <= pcmt_pkg::MSG_PME)
    && !((cmd_type_i == pcmt_pkg::MSG_PME)
    && (cmd_data_i[pcmt_pkg::PME_FN_HI:0] > pcmt_pkg::PME_FN_MAX));

  // ----------------------------------------------------------------
  // request holder
  // ----------------------------------------------------------------
  always_comb begin
    req_next = req_reg;
    type_next = type_reg;
    data_next = data_reg;
    done_next = 1'b0;
    if (req_reg && link.msg_tx_done) begin
      req_next = 1'b0; // drop right after the pulse
      done_next = 1'b1;
    end else if (!req_reg && cmd_valid_i && cmd_legal) begin
      // reserved requests are dropped silently
      req_next = 1'b1; // one outstanding only
      type_next = cmd_type_i;
      data_next = cmd_data_i;
    end
    ready_next = !req_next; // free again once the pulse is seen
  end

  // held steady while pending
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      req_reg <= 1'b0;
      type_reg <= 3'h0;
      data_reg <= 32'h0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      req_reg <= req_next;
      type_reg <= type_next;
      data_reg <= data_next;
      done_reg <= done_next;
      ready_reg <= ready_next;
    end
  end

  assign link.msg_tx_request_alias = req_reg;
  assign link.msg_tx_type = type_reg;
  assign link.msg_tx_data = data_reg;
  assign cmd_ready_o = ready_reg; // straight from a flop
  assign cmd_done_o = done_reg;

endmodule // pcmt_user
`default_nettype wire

// ==== src/pcmt_core.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcmt_core #(
  parameter int PROC_CYCLES = pcmt_pkg::DEF_PROC_CYCLES,
  parameter bit PASID_CAPABILITY_OPTION = 1'b0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // link
  pcmt_if.core link,
  // decoded message out
  output logic msg_valid_o,
  output logic [2:0] msg_type_o,
  output logic msg_snp_req_o,
  output logic [2:0] msg_snp_scale_o,
  output logic [9:0] msg_snp_value_o,
  output logic msg_nsp_req_o,
  output logic [2:0] msg_nsp_scale_o,
  output logic [9:0] msg_nsp_value_o,
  output logic [9:0] msg_sspl_o,
  output logic [1:0] msg_pme_fn_o,
  output logic msg_error_o,
  output logic [pcmt_pkg::SB_WIDTH-1:0] request_stream_user_sideband_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the counter is eight bits, so longer processing cannot be served
  if (PROC_CYCLES < 1 || PROC_CYCLES > 255) begin : g_bad_proc_cycles
    $error("PROC_CYCLES out of range");
  end

  typedef enum logic [1:0] {PCMT_IDLE, PCMT_BUSY, PCMT_DONE, PCMT_WAIT} pcmt_state_e;

  pcmt_state_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic valid_reg, valid_next;
  logic [2:0] type_reg, type_next;
  logic [31:0] data_reg, data_next;
  logic err_reg, err_next;
  logic [pcmt_pkg::SB_WIDTH-1:0] sb_reg, sb_next;

  // request legal for its type code and pme function
  function automatic logic req_legal(input logic [2:0] t, input logic [31:0] d);
    logic ok;
    ok = (t <= pcmt_pkg::MSG_PME);
    if (t == pcmt_pkg::MSG_PME && d[pcmt_pkg::PME_FN_HI:0] > pcmt_pkg::PME_FN_MAX)
      ok = 1'b0;
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  // one request with the default four processing cycles, edge by edge:
  //   c1 idle core takes the word and loads the counter with three
  //   c2 to c4 the counter runs down to zero
  //   c5 done and valid rise for one cycle, the sideband loads
  //   c6 done falls and the user end lowers its request
  //   c7 second skipped edge; a new word is taken from c8 on
  // the two skipped edges cost throughput but keep a late drop from
  // being taken again as a fresh request
  logic take_req;
  logic last_cycle;

  // take only from idle, and never when the option removes the port
  assign take_req = (state_reg == PCMT_IDLE) && link.msg_tx_request_alias
    && !PASID_CAPABILITY_OPTION;
  assign last_cycle = (state_reg == PCMT_BUSY) && (cnt_reg == 8'h0);

  // next state, counter and the two pulses
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    valid_next = 1'b0;
    unique case (state_reg)
      PCMT_IDLE: begin
        // port absent when option built: request ignored
        if (take_req) begin
          cnt_next = 8'(PROC_CYCLES - 1);
          state_next = PCMT_BUSY;
        end
      end
      PCMT_BUSY: begin
        if (last_cycle) begin
          valid_next = !err_reg; // reserved requests complete silently
          done_next = 1'b1; // exactly one cycle
          state_next = PCMT_DONE;
        end else begin
          cnt_next = cnt_reg - 8'h1;
        end
      end
      PCMT_DONE: begin
        // user drops request now; guard against a stale level
        state_next = PCMT_WAIT;
      end
      PCMT_WAIT: begin
        state_next = PCMT_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= PCMT_IDLE;
      cnt_reg <= 8'h0;
      done_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      valid_reg <= valid_next;
    end
  end

  // ----------------------------------------------------------------
  // captured request and its legality
  // ----------------------------------------------------------------
  // sampled once on the take edge, the user end holds it meanwhile
  always_comb begin
    type_next = type_reg;
    data_next = data_reg;
    err_next = err_reg;
    if (take_req) begin
      type_next = link.msg_tx_type;
      data_next = link.msg_tx_data;
      err_next = !req_legal(link.msg_tx_type, link.msg_tx_data);
      if (link.msg_tx_type == pcmt_pkg::MSG_OBFF)
        data_next = 32'h0; // content ignored
    end
  end

  // captured word stays until the next take
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      type_reg <= 3'h0;
      data_reg <= 32'h0;
      err_reg <= 1'b0;
    end else begin
      type_reg <= type_next;
      data_reg <= data_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // pasid sideband
  // ----------------------------------------------------------------
  // loads only when a legal latency report completes; other bits stay zero
  always_comb begin
    sb_next = sb_reg;
    if (last_cycle && type_reg == pcmt_pkg::MSG_LTR && !err_reg) begin
      sb_next[pcmt_pkg::SB_SNP_PASID_HI:pcmt_pkg::SB_SNP_PASID_LO] =
        data_reg[pcmt_pkg::LTR_SNP_PASID_HI:pcmt_pkg::LTR_SNP_PASID_LO];
      sb_next[pcmt_pkg::SB_NSP_PASID_HI:pcmt_pkg::SB_NSP_PASID_LO] =
        data_reg[pcmt_pkg::LTR_NSP_PASID_HI:pcmt_pkg::LTR_NSP_PASID_LO];
    end
  end

  // held between reports, so a later flush request leaves it alone
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sb_reg <= '0;
    end else begin
      sb_reg <= sb_next;
    end
  end

  // ----------------------------------------------------------------
  // done and valid pulses, then field outputs held from the captured word
  // ----------------------------------------------------------------
  assign link.msg_tx_done = done_reg;
  assign msg_valid_o = valid_reg;
  assign msg_type_o = type_reg;
  assign msg_error_o = err_reg;

  // snoop half of a latency report
  assign msg_snp_req_o = data_reg[pcmt_pkg::LTR_SNP_REQ_BIT];
  assign msg_snp_scale_o = data_reg[pcmt_pkg::LTR_SNP_SCALE_HI:pcmt_pkg::LTR_SNP_SCALE_LO];
  assign msg_snp_value_o = data_reg[pcmt_pkg::LTR_SNP_VAL_HI:pcmt_pkg::LTR_SNP_VAL_LO];

  // no-snoop half of a latency report
  assign msg_nsp_req_o = data_reg[pcmt_pkg::LTR_NSP_REQ_BIT];
  assign msg_nsp_scale_o = data_reg[pcmt_pkg::LTR_NSP_SCALE_HI:pcmt_pkg::LTR_NSP_SCALE_LO];
  assign msg_nsp_value_o = data_reg[pcmt_pkg::LTR_NSP_VAL_HI:pcmt_pkg::LTR_NSP_VAL_LO];

  // slot power word and pme function, meaningful only for their types
  assign msg_sspl_o = data_reg[pcmt_pkg::SSPL_HI:0];
  // only functions zero to three exist, so two bits carry them all
  assign msg_pme_fn_o = data_reg[1:0];
  assign request_stream_user_sideband_o = sb_reg;

endmodule // pcmt_core
`default_nettype wire

// ==== testbench/pcmt_link_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// link protocol checks
// ----------------------------------------
module pcmt_link_assertions (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // link signals
  input wire logic msg_tx_request_alias,
  input wire logic [2:0] msg_tx_type,
  input wire logic [31:0] msg_tx_data,
  input wire logic msg_tx_done
);
  // one domain, so clock and reset are shared by every property
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_done_one_cycle: assert property (msg_tx_done |=> !msg_tx_done)
    else $error("done wider than one cycle");
  a_done_needs_req: assert property (msg_tx_done |-> msg_tx_request_alias)
    else $error("done without a request");
  // window is wide; with the default four processing cycles done lands on its third cycle
  a_done_latency: assert property ($rose(msg_tx_request_alias) |->
    !msg_tx_done [*3] ##[1:8] msg_tx_done) else $error("done early or missing");
  a_req_hold: assert property (msg_tx_request_alias && !msg_tx_done |=>
    msg_tx_request_alias && $stable(msg_tx_type) && $stable(msg_tx_data))
    else $error("request changed before done");
  a_req_drop: assert property (msg_tx_done |=> !msg_tx_request_alias)
    else $error("request kept after done");
  a_drop_after_done: assert property ($fell(msg_tx_request_alias) |-> $past(msg_tx_done))
    else $error("request dropped without done");
  a_type_legal: assert property (msg_tx_request_alias |-> msg_tx_type <= pcmt_pkg::MSG_PME)
    else $error("reserved type on link");
  a_pme_func: assert property (msg_tx_request_alias && msg_tx_type == pcmt_pkg::MSG_PME
    |-> msg_tx_data[7:0] <= pcmt_pkg::PME_FN_MAX) else $error("reserved function");
endmodule // pcmt_link_assertions
`default_nettype wire

// ==== testbench/test_pcie_config_msg_transmit.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// user end and core joined over the link
// ----------------------------------------
module test_pcie_config_msg_transmit;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [2:0] cmd_type_i = 3'h0;
  logic [31:0] cmd_data_i = 32'h0;
  logic cmd_ready_o, cmd_done_o, mv, sr, nr, er;
  logic [2:0] ty, ss, ns;
  logic [9:0] sv, nv, sp;
  logic [1:0] fn;
  logic [182:0] sb;
  int error_cnt = 0;
  int n_tests = 0;
  int vcnt = 0;
  int sent = 0;
  pcmt_if lnk ();
  // 250 MHz clock and count of legal completions
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (mv === 1'b1) vcnt++;
  pcmt_user pcmt_user_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_type_i(cmd_type_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
    .cmd_done_o(cmd_done_o), .link(lnk.user));
  pcmt_core pcmt_core_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(lnk.core),
    .msg_valid_o(mv), .msg_type_o(ty), .msg_snp_req_o(sr), .msg_snp_scale_o(ss),
    .msg_snp_value_o(sv), .msg_nsp_req_o(nr), .msg_nsp_scale_o(ns), .msg_nsp_value_o(nv),
    .msg_sspl_o(sp), .msg_pme_fn_o(fn), .msg_error_o(er), .request_stream_user_sideband_o(sb));
  pcmt_link_assertions pcmt_link_assertions_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .msg_tx_request_alias(lnk.msg_tx_request_alias), .msg_tx_type(lnk.msg_tx_type),
    .msg_tx_data(lnk.msg_tx_data), .msg_tx_done(lnk.msg_tx_done));
  // field of a data word, right aligned
  function automatic logic [31:0] fld(input logic [31:0] d, input int hi, input int lo);
    return (d >> lo) & ((32'h1 << (hi - lo + 1)) - 32'h1);
  endfunction
  // what the user end may pass on: known code, pme function zero to three
  function automatic logic exp_legal(input logic [2:0] t, input logic [31:0] d);
    return t <= 3'h3 && !(t == 3'h3 && d[7:0] > 8'h03);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one command; reserved types and functions must be dropped with no done
  task automatic send(input logic [2:0] t, input logic [31:0] d);
    int n;
    n = 0;
    chk("ready", 32'h1, 32'(cmd_ready_o));
    cmd_valid_i <= 1'b1;
    cmd_type_i <= t;
    cmd_data_i <= d;
    @(posedge ref_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 30) begin
      @(posedge ref_clk_i);
      n++;
    end
    cmd_valid_i <= 1'b0;
    while (cmd_done_o !== 1'b1 && n < 30) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("done", 32'(exp_legal(t, d)), 32'(cmd_done_o));
    if (!exp_legal(t, d)) return;
    sent++;
    chk("type", 32'(t), 32'(ty));
    chk("error", 32'h0, 32'(er));
    case (t)
      pcmt_pkg::MSG_LTR: begin
        chk("snoop", fld(d, 31, 16) & 32'h9FFF, 32'({sr, 2'h0, ss, sv}));
        chk("nosnoop", fld(d, 15, 0) & 32'h9FFF, 32'({nr, 2'h0, ns, nv}));
        chk("sideband", (fld(d, 30, 29) << 2) | fld(d, 14, 13), 32'(sb[182:179]));
        chk("sideband rest", 32'h0, 32'(|sb[178:0]));
      end
      pcmt_pkg::MSG_OBFF: chk("flush", 32'h0, 32'(sp));
      pcmt_pkg::MSG_SSPL: chk("power", fld(d, 9, 0), 32'(sp));
      default: chk("function", fld(d, 1, 0), 32'(fn));
    endcase
  endtask
  // corner words first, then random traffic and reserved codes
  initial begin
    logic [31:0] d;
    logic [2:0] t;
    void'($urandom(10237));
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    send(pcmt_pkg::MSG_LTR, 32'hFFFFFFFF);
    send(pcmt_pkg::MSG_LTR, 32'h60006000);
    send(pcmt_pkg::MSG_PME, 32'hFFFFFF03);
    send(pcmt_pkg::MSG_PME, 32'h00000004);
    send(pcmt_pkg::MSG_SSPL, 32'hFFFFFFFF);
    send(pcmt_pkg::MSG_OBFF, 32'hFFFFFFFF);
    for (int i = 0; i < 40; i++) begin
      t = 3'($urandom % 4);
      d = $urandom;
      if (t == pcmt_pkg::MSG_PME && i % 2 == 0) d[7:2] = 6'h0;
      send(t, d);
    end
    for (int k = 4; k < 8; k++) send(3'(k), $urandom);
    send(pcmt_pkg::MSG_LTR, $urandom);
    chk("valid count", 32'(sent), 32'(vcnt));
    final_report;
  end
  // hang guard: some 50 commands of under 40 cycles each
  initial begin
    #20000;
    error_cnt++;
    final_report;
  end
endmodule // test_pcie_config_msg_transmit
`default_nettype wire
